/* verif/coc_host_model.sv */
// Command port host model issuing option, current and voltage commands
`timescale 1ns/1ns
module coc_host_model
(
    // Clock
    input wire logic i_clk,
    // Command port towards the device
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [7:0] o_cmd,
    output logic [15:0] o_wr_data,
    input wire logic [15:0] i_rd_data,
    input wire logic i_rd_valid
);
    initial
    begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_cmd = 8'h00;
        o_wr_data = 16'h0000;
    end

    // ************************************************************
    // Bus cycles, one strobe per cycle, released lines inverted
    // ************************************************************
    task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
        @(negedge i_clk);
        o_cmd = cmd;
        o_wr_data = data;
        o_wr_en = 1'b1;
        @(negedge i_clk);
        o_wr_en = 1'b0;
        // Stale values would hide a missing strobe qualification
        o_cmd = ~o_cmd;
        o_wr_data = ~o_wr_data;
    endtask

    task automatic rd(input logic [7:0] cmd, output logic [15:0] data, output logic ok);
        int n;
        @(negedge i_clk);
        o_cmd = cmd;
        o_rd_en = 1'b1;
        @(negedge i_clk);
        o_rd_en = 1'b0;
        o_cmd = ~o_cmd;
        // The answer stands one cycle only, so take it at this first edge
        ok = (i_rd_valid === 1'b1);
        data = i_rd_data;
        for (n = 0; n < 4 && ok == 1'b0; n++)
        begin
            @(negedge i_clk);
            ok = (i_rd_valid === 1'b1);
            data = i_rd_data;
        end
    endtask
endmodule

/* verif/tb.sv */
// Self-checking bench for the charge option register bank
`timescale 1ns/1ns
module tb;
    typedef struct packed
    {
        logic [15:0] d;
        logic [6:0] in;
        logic [9:0] ex;
    } coc_row_t;

    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic bpn = 1'b1;
    logic bo = 1'b0;
    logic rev = 1'b0;
    logic raw = 1'b0;
    logic lph = 1'b0;
    logic hot = 1'b0;
    logic mon = 1'b0;
    logic cmp = 1'b0;
    logic wr_en, rd_en, rd_valid, clr, wexp, ok;
    logic [7:0] cmd;
    logic [15:0] wdata, rd_data, option, rdv;
    coc_pkg::coc_ctrl_t ctrl;
    int bad_count = 0;
    int n_compared = 0;
    int n, hits;
    coc_row_t rows [5];

    always #2 i_clk = ~i_clk;

    coc_host_model u_coc_host_model (.i_clk(i_clk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_cmd(cmd),
        .o_wr_data(wdata), .i_rd_data(rd_data), .i_rd_valid(rd_valid));

    coc_option_reg #(.MS_CYCLES(18'd4)) u_coc_option_reg (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_wr_en(wr_en), .i_rd_en(rd_en), .i_cmd(cmd), .i_wr_data(wdata), .o_rd_data(rd_data),
        .o_rd_valid(rd_valid), .i_battery_present_n(bpn), .i_battery_only(bo),
        .i_reverse_boost_mode(rev), .i_adapter_good_raw(raw), .i_low_power_hot_profile_enable(lph),
        .i_hot_cfg_en(hot), .i_monitor_cfg_en(mon), .i_comparator_cfg_en(cmp), .o_option(option),
        .o_ctrl(ctrl), .o_charge_current_clear(clr), .o_watchdog_expired(wexp));

    // ************************************************************
    // Checking and closing
    // ************************************************************
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            bad_count++;
        end
    endtask

    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic read_chk(input logic [15:0] exp);
        u_coc_host_model.rd(8'h12, rdv, ok);
        chk("rd_valid", 16'h0001, {15'h0, ok});
        chk("rd_data", exp, rdv);
    endtask

    // Counts cycles to the clear pulse; a long bound catches a dead timer
    task automatic wait_clr(output int cnt);
        cnt = 0;
        while (clr !== 1'b1 && cnt < 25000)
        begin
            @(negedge i_clk);
            cnt++;
        end
        if (cnt >= 25000)
        begin
            $display("Error clear expected 1 seen timeout");
            bad_count++;
        end
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        // Inputs {bo, lph, rev, raw, hot, mon, cmp}; expected ctrl bits MSB first
        rows[0] = {16'h8002, 7'b1100010, 10'b0101010001};
        rows[1] = {16'he000, 7'b1000111, 10'b0000000001};
        rows[2] = {16'h0f00, 7'b1110101, 10'b1101101110};
        rows[3] = {16'h4000, 7'b0010010, 10'b1010100001};
        // Low power with adapter present is legal, only discouraged
        rows[4] = {16'h8802, 7'b0001111, 10'b1111111001};
        repeat (16) @(negedge i_clk);
        chk("option in reset", 16'he70e, option);
        i_rst_n = 1'b1;
        @(negedge i_clk);
        read_chk(16'he70e);
        $display("reset test done");
        foreach (rows[i])
        begin
            {bo, lph, rev, raw, hot, mon, cmp} = rows[i].in;
            u_coc_host_model.wr(8'h12, rows[i].d);
            repeat (6) @(negedge i_clk);
            chk("option", rows[i].d, option);
            read_chk(rows[i].d);
            chk("ctrl", {6'h0, rows[i].ex}, {6'h0, ctrl});
        end
        $display("table test done");
        u_coc_host_model.rd(8'h14, rdv, ok);
        chk("rd other valid", 16'h0001, {15'h0, ok});
        chk("rd other data", 16'h0000, rdv);
        bo = 1'b0;
        u_coc_host_model.wr(8'h12, 16'h1002);
        bpn = 1'b0;
        repeat (8) @(negedge i_clk);
        chk("auto off option", 16'h1000, option);
        chk("auto off loop", 16'h0000, {15'h0, ctrl.limit_loop_en});
        u_coc_host_model.wr(8'h12, 16'h1002);
        repeat (3) @(negedge i_clk);
        chk("loop restored", 16'h0001, {15'h0, ctrl.limit_loop_en});
        bpn = 1'b1;
        u_coc_host_model.wr(8'h12, 16'h0002);
        repeat (6) @(negedge i_clk);
        bpn = 1'b0;
        repeat (8) @(negedge i_clk);
        chk("auto off idle", 16'h0002, option);
        $display("auto off test done");
        // Short period, restarted half way so an unrestarted timer fires early
        u_coc_host_model.wr(8'h12, 16'h2000);
        repeat (10000) @(negedge i_clk);
        u_coc_host_model.wr(8'h14, 16'h0100);
        wait_clr(n);
        chk("period ok", 16'h0001, {15'h0, n >= 19995 && n <= 20010});
        if (n < 25000)
        begin
            @(negedge i_clk);
            chk("expired", 16'h0001, {15'h0, wexp});
            chk("clear pulse", 16'h0000, {15'h0, clr});
            u_coc_host_model.wr(8'h15, 16'h1000);
            repeat (3) @(negedge i_clk);
            chk("restarted", 16'h0000, {15'h0, wexp});
            u_coc_host_model.wr(8'h12, 16'h0000);
            hits = 0;
            repeat (22000)
            begin
                @(negedge i_clk);
                hits += int'(clr === 1'b1 || wexp === 1'b1);
            end
            chk("disabled", 16'h0000, 16'(hits));
            $display("watchdog test done");
            // Reset in mid-run must bring back the power-on settings
            i_rst_n = 1'b0;
            @(negedge i_clk);
            chk("option in mid reset", 16'he70e, option);
            chk("ctrl in mid reset", 16'h0000, {6'h0, ctrl});
            i_rst_n = 1'b1;
            @(negedge i_clk);
            read_chk(16'he70e);
            chk("ctrl after reset", 16'h03fe, {6'h0, ctrl});
            $display("mid reset test done");
        end
        close_out();
    end
endmodule

/* verilog/coc_defines.svh */
// Constants for the charge option register bank and its watchdog
// ************************************************************
// Overview of operation
// - Option register at command 12h, sixteen read/write bits, reset value E70Eh.
// - Low power bit with battery only: regulator off, hot, monitors, comparator, ADC off.
// - In low power, hot-profile enable bit still runs comparator and its hot profile.
// - Low power bit clear with battery only: blocks follow their own settings.
// - Watchdog select bits 14-13: off, 5 s, 88 s, 175 s; reset 11.
// - No charge current, voltage or option (12h) write within period forces charge current zero.
// - After expiry, writes to current, voltage or watchdog select restart timer.
// - With bit 12 set, battery_present_n falling clears bit 1; else untouched.
// - Bit 11 set drives adapter_good high during reverse boost mode.
// - Bit 10 set clamps light-load burst frequency above 25 kHz, both directions.
// - Bit 9 selects switching frequency: 0 is 1200 kHz, 1 is 800 kHz.
// - Bit 8 clear enables strong high-side turn-on drive; set disables it.
// - Bit 1 enables input-current regulation; the device may clear it.
// ************************************************************
`ifndef COC_DEFINES_SVH
`define COC_DEFINES_SVH

// ************************************************************
// Command addresses and reset value
// ************************************************************
`define COC_CMD_OPTION 8'h12
`define COC_CMD_CHG_CURRENT 8'h14
`define COC_CMD_CHG_VOLTAGE 8'h15
`define COC_OPTION_RESET 16'he70e

// ************************************************************
// Field positions
// ************************************************************
`define COC_BIT_LOW_POWER 15
`define COC_BIT_WDT_HI 14
`define COC_BIT_WDT_LO 13
`define COC_BIT_AUTO_OFF 12
`define COC_BIT_REV_AGOOD 11
`define COC_BIT_AUDIO 10
`define COC_BIT_FREQ 9
`define COC_BIT_STRONG_OFF 8
`define COC_BIT_LIMIT_EN 1

// ************************************************************
// Timing
// ************************************************************
`define COC_CLK_PERIOD_NS 4
`define COC_MS_NS 1000000
`define COC_MS_CYCLES (`COC_MS_NS / `COC_CLK_PERIOD_NS)
`define COC_WDT_P1_SEC 5
`define COC_WDT_P2_SEC 88
`define COC_WDT_P3_SEC 175
`define COC_MS_PER_SEC 1000

`endif

/* verilog/coc_option_reg.sv */
// Charge option register bank with low-power, watchdog and auto-disable logic
`timescale 1ns/1ns
`include "coc_defines.svh"
module coc_option_reg
#(
    parameter logic [17:0] MS_CYCLES = 18'(`COC_MS_CYCLES)
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Command port from the serial target front end
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_cmd,
    input wire logic [15:0] i_wr_data,
    output logic [15:0] o_rd_data,
    output logic o_rd_valid,
    // Pins, asynchronous to i_clk
    input wire logic i_battery_present_n,
    input wire logic i_battery_only,
    // Status and settings from neighbouring logic
    input wire logic i_reverse_boost_mode,
    input wire logic i_adapter_good_raw,
    input wire logic i_low_power_hot_profile_enable,
    input wire logic i_hot_cfg_en,
    input wire logic i_monitor_cfg_en,
    input wire logic i_comparator_cfg_en,
    // Option register contents
    output logic [15:0] o_option,
    // Controls towards the converter
    output coc_pkg::coc_ctrl_t o_ctrl,
    output logic o_charge_current_clear,
    output logic o_watchdog_expired
);

    coc_pkg::coc_state_t state_reg;
    coc_pkg::coc_state_t state_next;
    logic wdt_restart;
    logic wdt_expire;
    logic wdt_expired;
    logic low_power_active;
    logic bp_fall;
    logic [15:0] opt_after_wr;

    function automatic logic cmd_hit(input logic [7:0] cmd, input logic [7:0] addr);
        cmd_hit = (cmd == addr);
    endfunction

    // ************************************************************
    // Watchdog
    // ************************************************************
    // Writing 12h always rewrites the watchdog select field, so it restarts too
    assign wdt_restart = i_wr_en && (cmd_hit(i_cmd, `COC_CMD_CHG_CURRENT)
        || cmd_hit(i_cmd, `COC_CMD_CHG_VOLTAGE) || cmd_hit(i_cmd, `COC_CMD_OPTION));

    coc_watchdog #(
        .MS_CYCLES(MS_CYCLES)
    ) u_watchdog (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_restart(wdt_restart),
        .i_period(coc_pkg::coc_wdt_sel_t'(state_reg.option[`COC_BIT_WDT_HI:`COC_BIT_WDT_LO])),
        .o_expire(wdt_expire),
        .o_expired(wdt_expired)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    // Low power applies only with the battery as sole source
    assign low_power_active = state_reg.option[`COC_BIT_LOW_POWER] && state_reg.bo_sync;
    assign bp_fall = state_reg.bp_prev && !state_reg.bp_sync;

    always_comb
    begin
        state_next = state_reg;
        // Two-stage synchronisers for the pins
        state_next.bp_meta = i_battery_present_n;
        state_next.bp_sync = state_reg.bp_meta;
        state_next.bp_prev = state_reg.bp_sync;
        state_next.bo_meta = i_battery_only;
        state_next.bo_sync = state_reg.bo_meta;

        opt_after_wr = state_reg.option;
        if (i_wr_en && cmd_hit(i_cmd, `COC_CMD_OPTION))
        begin
            opt_after_wr = i_wr_data;
        end
        // Hardware clear beats a same-cycle host write so the removal is not lost
        if (bp_fall && state_reg.option[`COC_BIT_AUTO_OFF])
        begin
            opt_after_wr[`COC_BIT_LIMIT_EN] = 1'b0;
        end
        state_next.option = opt_after_wr;

        state_next.rd_valid = i_rd_en;
        if (i_rd_en && cmd_hit(i_cmd, `COC_CMD_OPTION))
        begin
            state_next.rd_data = state_reg.option;
        end
        else
        begin
            // Other commands live in other banks; answer zero here
            state_next.rd_data = 16'h0000;
        end

        state_next.chg_clear = wdt_expire;
        state_next.wdt_expired = wdt_expired;

        state_next.ctrl.regulator_on = !low_power_active;
        state_next.ctrl.adc_avail = !low_power_active;
        if (low_power_active)
        begin
            state_next.ctrl.monitor_buf_en = 1'b0;
            state_next.ctrl.hot_logic_en = i_low_power_hot_profile_enable;
            state_next.ctrl.comparator_en = i_low_power_hot_profile_enable;
        end
        else
        begin
            state_next.ctrl.monitor_buf_en = i_monitor_cfg_en;
            state_next.ctrl.hot_logic_en = i_hot_cfg_en;
            state_next.ctrl.comparator_en = i_comparator_cfg_en;
        end
        state_next.ctrl.limit_loop_en = state_reg.option[`COC_BIT_LIMIT_EN];
        state_next.ctrl.adapter_good = i_adapter_good_raw
            || (state_reg.option[`COC_BIT_REV_AGOOD] && i_reverse_boost_mode);
        state_next.ctrl.audio_clamp = state_reg.option[`COC_BIT_AUDIO];
        state_next.ctrl.freq_800k = state_reg.option[`COC_BIT_FREQ];
        state_next.ctrl.strong_drive_en = !state_reg.option[`COC_BIT_STRONG_OFF];
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg <= '0;
            state_reg.option <= `COC_OPTION_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign o_option = state_reg.option;
    assign o_rd_data = state_reg.rd_data;
    assign o_rd_valid = state_reg.rd_valid;
    assign o_ctrl = state_reg.ctrl;
    assign o_charge_current_clear = state_reg.chg_clear;
    assign o_watchdog_expired = state_reg.wdt_expired;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    opt_write_a: assert property (
        (i_wr_en && i_cmd == `COC_CMD_OPTION && !(bp_fall && state_reg.option[`COC_BIT_AUTO_OFF]))
        |=> o_option == $past(i_wr_data))
        else $error("option write not stored");
    opt_read_a: assert property (
        (i_rd_en && i_cmd == `COC_CMD_OPTION) |=> (o_rd_valid && o_rd_data == $past(o_option)))
        else $error("option read returned wrong data");
    lp_shutdown_a: assert property (
        low_power_active |=> (!o_ctrl.regulator_on && !o_ctrl.adc_avail && !o_ctrl.monitor_buf_en))
        else $error("low power did not shut blocks off");
    lp_profile_a: assert property (
        low_power_active |=> o_ctrl.comparator_en == $past(i_low_power_hot_profile_enable))
        else $error("low power comparator not following profile enable");
    perf_follow_a: assert property (
        !low_power_active |=> (o_ctrl.hot_logic_en == $past(i_hot_cfg_en)
        && o_ctrl.monitor_buf_en == $past(i_monitor_cfg_en) && o_ctrl.regulator_on))
        else $error("performance mode not following settings");
    wdt_clear_a: assert property (
        wdt_expire |=> o_charge_current_clear ##1 !o_charge_current_clear)
        else $error("watchdog expiry did not clear charge current once");
    auto_off_a: assert property (
        (bp_fall && state_reg.option[`COC_BIT_AUTO_OFF]) |=> !o_option[`COC_BIT_LIMIT_EN] ##1 !o_ctrl.limit_loop_en)
        else $error("auto disable did not clear limit enable");
    auto_keep_a: assert property (
        (!state_reg.option[`COC_BIT_AUTO_OFF] && !i_wr_en) |=> $stable(o_option))
        else $error("limit enable changed without cause");
    rev_agood_a: assert property (
        (state_reg.option[`COC_BIT_REV_AGOOD] && i_reverse_boost_mode) |=> o_ctrl.adapter_good)
        else $error("adapter good low in reverse mode");
    drive_bits_a: assert property (
        1'b1 |=> (o_ctrl.audio_clamp == $past(o_option[`COC_BIT_AUDIO])
        && o_ctrl.freq_800k == $past(o_option[`COC_BIT_FREQ])
        && o_ctrl.strong_drive_en != $past(o_option[`COC_BIT_STRONG_OFF])))
        else $error("converter settings do not track option bits");

    // Strobe answers and level tracking
    rd_zero_a: assert property (
        (i_rd_en && i_cmd != `COC_CMD_OPTION) |=> (o_rd_valid && o_rd_data == 16'h0000))
        else $error("read of another command did not answer zero");
    rearm_clear_a: assert property (
        wdt_restart |=> ##1 !o_watchdog_expired)
        else $error("restart did not clear the expired flag");
    lp_hot_a: assert property (
        low_power_active |=> o_ctrl.hot_logic_en == $past(i_low_power_hot_profile_enable))
        else $error("low power hot logic not following profile enable");
    perf_cmp_a: assert property (
        !low_power_active |=> (o_ctrl.comparator_en == $past(i_comparator_cfg_en) && o_ctrl.adc_avail))
        else $error("performance mode comparator not following setting");
    loop_track_a: assert property (
        1'b1 |=> o_ctrl.limit_loop_en == $past(o_option[`COC_BIT_LIMIT_EN]))
        else $error("limit loop enable not tracking its bit");
    agood_raw_a: assert property (
        !(state_reg.option[`COC_BIT_REV_AGOOD] && i_reverse_boost_mode)
        |=> o_ctrl.adapter_good == $past(i_adapter_good_raw))
        else $error("adapter good not following the raw level");
    clear_cause_a: assert property (
        o_charge_current_clear |-> $past(wdt_expire))
        else $error("charge current cleared without expiry");

    lp_entry_c: cover property (!low_power_active ##1 low_power_active);
    wdt_fire_c: cover property (wdt_expire);
    auto_off_c: cover property (bp_fall && state_reg.option[`COC_BIT_AUTO_OFF]);
    rev_agood_c: cover property (o_ctrl.adapter_good && !i_adapter_good_raw);
    wdt_rearm_c: cover property (wdt_expired && wdt_restart);

endmodule

/* verilog/coc_pkg.sv */
// Types for the charge option register bank
package coc_pkg;

    typedef enum logic [1:0]
    {
        COC_WDT_OFF = 2'b00,
        COC_WDT_SHORT = 2'b01,
        COC_WDT_MID = 2'b10,
        COC_WDT_LONG = 2'b11
    } coc_wdt_sel_t;

    typedef struct packed
    {
        logic [17:0] pre_cnt;
        logic [17:0] ms_cnt;
        logic expired;
        logic expire_pulse;
    } coc_wdt_state_t;

    typedef struct packed
    {
        logic regulator_on;
        logic hot_logic_en;
        logic monitor_buf_en;
        logic comparator_en;
        logic adc_avail;
        logic limit_loop_en;
        logic adapter_good;
        logic audio_clamp;
        logic freq_800k;
        logic strong_drive_en;
    } coc_ctrl_t;

    typedef struct packed
    {
        logic [15:0] option;
        logic bp_meta;
        logic bp_sync;
        logic bp_prev;
        logic bo_meta;
        logic bo_sync;
        logic [15:0] rd_data;
        logic rd_valid;
        logic chg_clear;
        logic wdt_expired;
        coc_ctrl_t ctrl;
    } coc_state_t;

endpackage

/* verilog/coc_watchdog.sv */
// Charge command watchdog timer with millisecond prescaler
`timescale 1ns/1ns
`include "coc_defines.svh"
module coc_watchdog
#(
    parameter logic [17:0] MS_CYCLES = 18'(`COC_MS_CYCLES)
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Control
    input wire logic i_restart,
    input wire coc_pkg::coc_wdt_sel_t i_period,
    // Status
    output logic o_expire,
    output logic o_expired
);

    coc_pkg::coc_wdt_state_t state_reg;
    coc_pkg::coc_wdt_state_t state_next;
    logic [17:0] limit_ms;

    // ************************************************************
    // Period decode
    // ************************************************************
    always_comb
    begin
        case (i_period)
            coc_pkg::COC_WDT_SHORT: limit_ms = 18'(`COC_WDT_P1_SEC * `COC_MS_PER_SEC);
            coc_pkg::COC_WDT_MID: limit_ms = 18'(`COC_WDT_P2_SEC * `COC_MS_PER_SEC);
            coc_pkg::COC_WDT_LONG: limit_ms = 18'(`COC_WDT_P3_SEC * `COC_MS_PER_SEC);
            default: limit_ms = 18'h00000;
        endcase
    end

    // ************************************************************
    // Counter
    // ************************************************************
    always_comb
    begin
        state_next = state_reg;
        state_next.expire_pulse = 1'b0;
        if (i_restart)
        begin
            // Any qualifying write starts a fresh full period
            state_next.pre_cnt = 18'h00000;
            state_next.ms_cnt = 18'h00000;
            state_next.expired = 1'b0;
        end
        else if (i_period == coc_pkg::COC_WDT_OFF || state_reg.expired)
        begin
            // Disabled or already fired: hold until restart
            state_next.pre_cnt = 18'h00000;
        end
        else if (state_reg.pre_cnt == MS_CYCLES - 18'h00001)
        begin
            state_next.pre_cnt = 18'h00000;
            if (state_reg.ms_cnt + 18'h00001 >= limit_ms)
            begin
                state_next.expired = 1'b1;
                state_next.expire_pulse = 1'b1;
            end
            else
            begin
                state_next.ms_cnt = state_reg.ms_cnt + 18'h00001;
            end
        end
        else
        begin
            state_next.pre_cnt = state_reg.pre_cnt + 18'h00001;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign o_expire = state_reg.expire_pulse;
    assign o_expired = state_reg.expired;

    // ************************************************************
    // Checks
    // ************************************************************
    wdt_off_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_period == coc_pkg::COC_WDT_OFF && !i_restart) |=> !state_reg.expire_pulse)
        else $error("watchdog fired while disabled");
    wdt_restart_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_restart |=> (!state_reg.expired && state_reg.ms_cnt == 18'h00000))
        else $error("watchdog restart did not clear the timer");
    wdt_pulse_once_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state_reg.expire_pulse |-> (state_reg.expired && !$past(state_reg.expired)))
        else $error("watchdog pulse without fresh expiry");

endmodule
